// ==== logic/freq_divider_pkg.sv ====
// Constants for the programmable frequency divider and its source tick generator.
// Assumes a single 200 MHz clock and an 8-bit register port at byte offsets.
// What this block does
// - Tone output toggles only while the enable bit is one, else held low.
// - Control bits 6 and 5 select prescale by 1, 2, 4 or 8.
// - Control bit 7 picks high-speed clock over four, else the 32768 Hz clock.
// - An 8-bit writable count register sets the counter terminal count.
// - Writes to the count register are ignored while the divider is disabled.
// - Hardware clears the count register whenever the divider is disabled.
// - Output frequency is prescaler frequency over two times the sum of count and one.
package freq_divider_pkg;
  localparam logic [7:0] divider_control_offset = 8'h2e;
  localparam logic [7:0] divider_count_offset = 8'h2f;
  localparam logic [7:0] divider_control_reset = 8'h00;
  localparam logic [7:0] divider_count_reset = 8'h00;
  localparam int source_clock_sel_bit = 7;
  localparam int prescale_sel_hi_bit = 6;
  localparam int prescale_sel_lo_bit = 5;
  localparam int tone_output_enable_bit = 4;
  localparam logic [7:0] control_read_mask = 8'hf0;
  localparam logic [1:0] hs_divide_last = 2'h3;
endpackage

// ==== logic/source_tick_gen.sv ====
// Source clock selection and prescaler, producing one-cycle ticks.
// Assumes both source clocks arrive as pins asynchronous to ref_clk.
`timescale 1ns/10ps
module source_tick_gen (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Source clock pins
  input wire logic hs_clk_pin,
  input wire logic lf_clk_pin,
  // Control
  input wire logic run,
  input wire logic source_clock_sel,
  input wire logic [1:0] prescale_sel,
  // Prescaler output
  output logic tick
);
  typedef struct packed {
    logic hs_s1;
    logic hs_s2;
    logic hs_d;
    logic lf_s1;
    logic lf_s2;
    logic lf_d;
    logic [1:0] hs_div;
    logic [2:0] pre;
    logic tick;
  } gen_state_t;

  gen_state_t st;
  gen_state_t next_st;
  logic hs_edge;
  logic lf_edge;
  logic src_tick;
  logic [2:0] mask;

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_st = st;
    next_st.hs_s1 = hs_clk_pin;
    next_st.hs_s2 = st.hs_s1;
    next_st.hs_d = st.hs_s2;
    next_st.lf_s1 = lf_clk_pin;
    next_st.lf_s2 = st.lf_s1;
    next_st.lf_d = st.lf_s2;
    hs_edge = st.hs_s2 & ~st.hs_d;
    lf_edge = st.lf_s2 & ~st.lf_d;
    next_st.tick = 1'b0;
    if (hs_edge) begin
      next_st.hs_div = st.hs_div + 2'h1;
    end
    src_tick = source_clock_sel ? (hs_edge && st.hs_div == freq_divider_pkg::hs_divide_last)
                                : lf_edge;
    case (prescale_sel)
      2'h0: mask = 3'h0;
      2'h1: mask = 3'h1;
      2'h2: mask = 3'h3;
      default: mask = 3'h7;
    endcase
    if (!run) begin
      next_st.pre = 3'h0;
    end else if (src_tick) begin
      next_st.pre = st.pre + 3'h1;
      next_st.tick = ((st.pre & mask) == mask);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule

// ==== logic/freq_divider.sv ====
// Programmable frequency divider top: register port, counter and tone output.
// Assumes one 200 MHz clock, source clocks on pins, and a one-cycle register port.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
module freq_divider (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  // Source clock pins
  input wire logic hs_clk_pin,
  input wire logic lf_clk_pin,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Tone output
  output logic tone_out_pin
);
  typedef struct packed {
    logic [7:0] divider_control;
    logic [7:0] divider_count;
    logic [7:0] count;
    logic tone;
    logic [7:0] rdata;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;
  logic rst_s1;
  logic rst_n;
  logic tick;
  logic enabled;

  //////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops.

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  assign enabled = st.divider_control[freq_divider_pkg::tone_output_enable_bit];

  source_tick_gen u_ticks (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .hs_clk_pin(hs_clk_pin),
    .lf_clk_pin(lf_clk_pin),
    .run(enabled),
    .source_clock_sel(st.divider_control[freq_divider_pkg::source_clock_sel_bit]),
    .prescale_sel(st.divider_control[freq_divider_pkg::prescale_sel_hi_bit:
                                     freq_divider_pkg::prescale_sel_lo_bit]),
    .tick(tick)
  );

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    if (rd) begin
      if (addr == freq_divider_pkg::divider_control_offset) begin
        next_st.rdata = st.divider_control & freq_divider_pkg::control_read_mask;
      end else if (addr == freq_divider_pkg::divider_count_offset) begin
        next_st.rdata = st.divider_count;
      end
    end
    if (wr && addr == freq_divider_pkg::divider_control_offset) begin
      next_st.divider_control = wdata & freq_divider_pkg::control_read_mask;
    end
    if (wr && addr == freq_divider_pkg::divider_count_offset && enabled) begin
      next_st.divider_count = wdata;
    end
    if (!enabled) begin
      next_st.divider_count = freq_divider_pkg::divider_count_reset;
      next_st.tone = 1'b0;
      next_st.count = 8'h00;
    end else if (tick) begin
      if (st.count == 8'h00) begin
        next_st.count = st.divider_count;
        next_st.tone = ~st.tone;
      end else begin
        next_st.count = st.count - 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st.divider_control <= freq_divider_pkg::divider_control_reset;
      st.divider_count <= freq_divider_pkg::divider_count_reset;
      st.count <= 8'h00;
      st.tone <= 1'b0;
      st.rdata <= 8'h00;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign tone_out_pin = st.tone;
endmodule

// ==== test/freq_divider_checker.sv ====
// Port checker for the frequency divider.
// Attempts are dropped while ce is low; assumes the source pins run slowly.
`timescale 1ns/10ps
module freq_divider_checker (
  // Watched ports
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic tone_out_pin
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n || !ce);
  AST_RD_IDLE: assert property (!rd |=> rdata == 8'h00)
    else $error("rdata set without read");
  AST_UNMAPPED: assert property (rd && addr != 8'h2e && addr != 8'h2f |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CTRL_RB: assert property (wr && addr == 8'h2e ##1 rd && addr == 8'h2e
    |=> rdata == ($past(wdata, 2) & freq_divider_pkg::control_read_mask)) else $error("ctrl");
  AST_CNT_RB: assert property (wr && addr == 8'h2e && wdata[4] ##1 wr && addr == 8'h2f
    ##1 rd && addr == 8'h2f |=> rdata == $past(wdata, 2)) else $error("count readback");
  AST_CNT_LOCK: assert property (wr && addr == 8'h2e && !wdata[4] ##1 wr && addr == 8'h2f
    ##1 rd && addr == 8'h2f |=> rdata == 8'h00) else $error("count written while off");
  AST_CNT_CLR: assert property (wr && addr == 8'h2e && !wdata[4] ##1 !wr [*2]
    ##1 rd && addr == 8'h2f |=> rdata == 8'h00) else $error("count not cleared");
  AST_TONE_OFF: assert property (wr && addr == 8'h2e && !wdata[4]
    ##1 !(wr && addr == 8'h2e) [*3] |-> !tone_out_pin [*4])
    else $error("tone not low while off");
  AST_TONE_HOLD: assert property ($changed(tone_out_pin) |=> $stable(tone_out_pin) [*3])
    else $error("tone toggled too soon");
endmodule
bind freq_divider freq_divider_checker i_freq_divider_checker (.ref_clk, .arst_n, .ce, .addr,
  .wdata, .wr, .rd, .rdata, .tone_out_pin);

// ==== test/freq_divider_test.sv ====
// Bench for the frequency divider: register port and tone periods.
// Assumes fast stand-in source clocks so that tone periods stay short.
`timescale 1ns/10ps
module freq_divider_test;
  logic ref_clk, arst_n, ce, wr, rd, tone_out_pin;
  logic hs_clk_pin = 1'b0;
  logic lf_clk_pin = 1'b0;
  logic [7:0] addr, wdata, rdata;
  int mismatches, num_checks;
  realtime t0;
  freq_divider i_freq_divider (.ref_clk, .arst_n, .ce, .hs_clk_pin, .lf_clk_pin,
    .addr, .wdata, .wr, .rd, .rdata, .tone_out_pin);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Source ticks every 32 and every 40 reference cycles.
  always #20 hs_clk_pin = ~hs_clk_pin;
  always #100 lf_clk_pin = ~lf_clk_pin;
  task op(input logic w, r, input logic [7:0] a, d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
  endtask
  task chk(input string what, input logic [15:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task rd_chk(input logic [7:0] a, exp);
    op(1'b0, 1'b1, a, 8'h00);
    rd <= 1'b0;
    @(negedge ref_clk);
    chk("rdata", {8'h00, exp}, {8'h00, rdata});
    @(posedge ref_clk);
  endtask
  task tone_chk(input logic [15:0] exp);
    repeat (2) @(posedge tone_out_pin);
    t0 = $realtime;
    @(posedge tone_out_pin);
    chk("tone period", exp, 16'(int'(($realtime - t0) / 5.0)));
    t0 = $realtime;
    @(negedge tone_out_pin);
    chk("tone high time", exp >> 1, 16'(int'(($realtime - t0) / 5.0)));
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    {arst_n, wr, rd, addr, wdata} = '0;
    ce = 1'b1;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd_chk(8'h2e, 8'h00);
    op(1'b1, 1'b0, 8'h2e, 8'h0f);
    op(1'b1, 1'b0, 8'h2f, 8'h5a);
    rd_chk(8'h2f, 8'h00);
    chk("tone", 16'h0000, {15'h0000, tone_out_pin});
    rd_chk(8'h2d, 8'h00);
    op(1'b1, 1'b0, 8'h2e, 8'h9f);
    rd_chk(8'h2e, 8'h90);
    for (int s = 0; s < 4; s++) begin
      op(1'b1, 1'b0, 8'h2e, {1'b1, 2'(s), 5'h10});
      op(1'b1, 1'b0, 8'h2f, 8'(s));
      rd_chk(8'h2f, 8'(s));
      tone_chk(16'(32'h40 * (s + 1) << s));
    end
    op(1'b1, 1'b0, 8'h2e, 8'h10);
    rd_chk(8'h2e, 8'h10);
    tone_chk(16'h0140);
    // A write while ce is low must leave the control register as it was.
    ce <= 1'b0;
    op(1'b1, 1'b0, 8'h2e, 8'h90);
    ce <= 1'b1;
    rd_chk(8'h2e, 8'h10);
    // Disable while the tone is high, so that the forced low level is seen.
    @(posedge tone_out_pin);
    repeat (9) @(posedge ref_clk);
    op(1'b1, 1'b0, 8'h2e, 8'h00);
    op(1'b0, 1'b0, 8'h2e, 8'h00);
    op(1'b0, 1'b0, 8'h2e, 8'h00);
    rd_chk(8'h2f, 8'h00);
    chk("tone", 16'h0000, {15'h0000, tone_out_pin});
    repeat (4) @(posedge ref_clk);
    tally_and_finish;
  end
endmodule
